// File: verilog/tpr_pkg.sv
/*
 * Package for the touch pattern and recalibration control block: register
 * indices, field positions, reset values, decode tables and carrier structs.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package tpr_pkg;

  localparam int NUM_INPUTS = 6;
  localparam int REG_W = 8;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_MAIN_STATUS = 8'h02;
  localparam logic [7:0] IDX_PATTERN_SELECT = 8'h20;
  localparam logic [7:0] IDX_PATTERN_CONFIG = 8'h2B;
  localparam logic [7:0] IDX_RANGE_FLAGS = 8'h2E;
  localparam logic [7:0] IDX_RECAL_SETUP = 8'h2F;
  localparam logic [7:0] IDX_THRESH_FIRST = 8'h30;
  localparam logic [7:0] IDX_THRESH_LAST = 8'h35;

  // reset values
  localparam logic [7:0] RST_PATTERN_SELECT = 8'h3F;
  localparam logic [7:0] RST_PATTERN_CONFIG = 8'h00;
  localparam logic [7:0] RST_RANGE_FLAGS = 8'h00;
  localparam logic [7:0] RST_RECAL_SETUP = 8'h8A;
  localparam logic [6:0] RST_THRESHOLD = 7'h40;

  // pattern configuration fields
  localparam int PC_DETECT_EN = 7;
  localparam int PC_FRAC_HI = 3;
  localparam int PC_FRAC_LO = 2;
  localparam int PC_COMPARE = 1;
  localparam int PC_ALERT_EN = 0;

  // recalibration setup fields
  localparam int RS_BROADCAST = 7;
  localparam int RS_KEEP_INTD = 6;
  localparam int RS_KEEP_NEG = 5;
  localparam int RS_NEG_HI = 4;
  localparam int RS_NEG_LO = 3;
  localparam int RS_CAL_HI = 2;
  localparam int RS_CAL_LO = 0;

  // main status fields
  localparam int ST_ALERT = 0;
  localparam int ST_BASE_FAULT = 1;
  localparam int ST_PATTERN = 2;

  // negative delta recalibration counts
  localparam int NEG_CNT_W = 6;
  localparam logic [NEG_CNT_W-1:0] NEG_LIMIT_8 = 6'h08;
  localparam logic [NEG_CNT_W-1:0] NEG_LIMIT_16 = 6'h10;
  localparam logic [NEG_CNT_W-1:0] NEG_LIMIT_32 = 6'h20;
  localparam logic [1:0] NEG_CODE_OFF = 2'h3;

  // recalibration samples (log2) and update interval (sensing cycles)
  localparam int IVL_W = 13;
  localparam logic [3:0] SAMPLES_MIN_LOG2 = 4'h4;
  localparam logic [3:0] SAMPLES_MAX_LOG2 = 4'h8;
  localparam logic [2:0] CAL_CODE_CAP = 3'h4;
  localparam logic [IVL_W-1:0] IVL_TABLE [8] = '{13'h0010, 13'h0020, 13'h0040,
      13'h0080, 13'h0100, 13'h0400, 13'h0800, 13'h1000};

  // sensing results of one cycle, from the analog front end
  typedef struct packed {
    logic [NUM_INPUTS-1:0] over_pattern;
    logic [NUM_INPUTS-1:0] noise;
    logic [NUM_INPUTS-1:0] neg_delta;
  } tpr_sense_s;

  // recalibration controls toward the front end
  typedef struct packed {
    logic [NUM_INPUTS-1:0] clear_intermediate;
    logic [NUM_INPUTS-1:0] recal_request;
    logic base_update;
    logic [3:0] samples_log2;
  } tpr_recal_s;

endpackage : tpr_pkg

// File: verilog/tpr_neg_counter.sv
/*
 * One input's consecutive negative delta counter.
 * Assumes step pulses come once per sensing cycle from the same clock.
 */
module tpr_neg_counter
  import tpr_pkg::*;
#(
  parameter int W = NEG_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic negative,
  input wire logic noise_clear,
  input wire logic enable,
  input wire logic [W-1:0] limit,
  output logic recal
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic recal_reg;
  logic recal_next;

  // count only unbroken runs; reaching the limit fires once and restarts
  always_comb begin
    count_next = count_reg;
    recal_next = 1'b0;
    if (noise_clear) begin
      count_next = '0;
    end else if (step) begin
      if (!negative || !enable) begin
        count_next = '0;
      end else if (count_reg + W'(1) >= limit) begin
        count_next = '0;
        recal_next = 1'b1;
      end else begin
        count_next = count_reg + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      recal_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      recal_reg <= recal_next;
    end
  end

  assign recal = recal_reg;

endmodule : tpr_neg_counter

// File: verilog/tpr_top.sv
/*
 * Touch pattern detection, base count range flags and recalibration control
 * of a six input capacitive touch controller, with an APB register slave.
 * Assumes the front end delivers per-cycle results on pclk with a one-cycle
 * cycle_done pulse, and calibration results with a calib_valid pulse.
 */
// The implementer's own choice: the APB register port.
// How it works
// - mask bit n selects input n+1
// - specific mode: all selected inputs qualify
// - count mode: qualifiers at least mask popcount
// - compare bit chooses evaluation method
// - compare 1 specific, 0 count, resets 0
// - detection only while enable bit set
// - event blocks touches, sets pattern status
// - alert pin only with alert enable
// - per-input read-only base range flags
// - any range flag sets summary fault
// - broadcast bit copies input-1 threshold writes
// - noise clears intermediate data unless kept
// - noise clears negative counter unless kept
// - negative run of 8/16/32 triggers recalibration
// - samples 16..128, codes above give 256
// - update interval 16..256, 1024, 2048, 4096
// - samples never set the update interval
// - one setting applies to all inputs
module tpr_top
  import tpr_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int N = NUM_INPUTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_done,
  input wire tpr_sense_s sense,
  input wire logic calib_valid,
  input wire logic [N-1:0] base_out_range,
  output logic touch_block,
  output logic alert_n,
  output logic [N*7-1:0] thresholds,
  output tpr_recal_s recal
);

  logic [REG_W-1:0] pattern_select_reg, pattern_select_next;
  logic [REG_W-1:0] pattern_config_reg, pattern_config_next;
  logic [REG_W-1:0] recal_setup_reg, recal_setup_next;
  logic [N-1:0] range_flags_reg, range_flags_next;
  logic [6:0] thresh_reg [N];
  logic [6:0] thresh_next [N];
  logic pattern_active_reg, pattern_active_next;
  logic pattern_status_reg, pattern_status_next;
  logic alert_flag_reg, alert_flag_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [IVL_W-1:0] ivl_count_reg, ivl_count_next;
  logic update_reg, update_next;

  logic [7:0] idx;
  logic aligned;
  logic setup_phase;
  logic wr_access;
  logic lane0;
  logic [7:0] wbyte;
  logic [N-1:0] qualify;
  logic [3:0] qual_count;
  logic [3:0] mask_count;
  logic hit;
  logic [REG_W-1:0] status_view;
  logic [NEG_CNT_W-1:0] neg_limit;
  logic [IVL_W-1:0] ivl_limit;
  logic [2:0] cal_code;
  logic [N-1:0] noise_clear_neg;

  // address decode; a misaligned byte address answers with an error
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign cal_code = recal_setup_reg[RS_CAL_HI:RS_CAL_LO];

  // qualifying inputs and population counts for the pattern compare
  always_comb begin
    qualify = '0;
    qual_count = '0;
    mask_count = '0;
    if (pattern_config_reg[PC_DETECT_EN]) begin
      qualify = sense.over_pattern | sense.noise;
    end
    for (int i = 0; i < N; i++) begin
      qual_count = qual_count + 4'(qualify[i]);
      mask_count = mask_count + 4'(pattern_select_reg[i]);
    end
    if (pattern_config_reg[PC_COMPARE]) begin
      hit = ((qualify & pattern_select_reg[N-1:0]) == pattern_select_reg[N-1:0])
          && (pattern_select_reg[N-1:0] != '0);
    end else begin
      hit = (qual_count >= mask_count) && (qual_count != 4'h0);
    end
  end

  // status view; summary fault follows the live flags
  always_comb begin
    status_view = '0;
    status_view[ST_ALERT] = alert_flag_reg;
    status_view[ST_BASE_FAULT] = |range_flags_reg;
    status_view[ST_PATTERN] = pattern_status_reg;
  end

  // pattern evaluation once per sensing cycle; event sets win over clears
  always_comb begin
    pattern_active_next = pattern_active_reg;
    pattern_status_next = pattern_status_reg;
    alert_flag_next = alert_flag_reg;
    if (wr_access && aligned && idx == IDX_MAIN_STATUS && lane0 && !wbyte[ST_ALERT]) begin
      alert_flag_next = 1'b0;
      // status only drops once the condition has gone
      if (!pattern_active_reg) begin
        pattern_status_next = 1'b0;
      end
    end
    if (cycle_done) begin
      pattern_active_next = hit;
      if (hit) begin
        pattern_status_next = 1'b1;
        if (pattern_config_reg[PC_ALERT_EN]) begin
          alert_flag_next = 1'b1;
        end
      end
    end
  end

  // register writes; thresholds take a broadcast from input 1
  always_comb begin
    pattern_select_next = pattern_select_reg;
    pattern_config_next = pattern_config_reg;
    recal_setup_next = recal_setup_reg;
    range_flags_next = range_flags_reg;
    for (int i = 0; i < N; i++) begin
      thresh_next[i] = thresh_reg[i];
    end
    if (calib_valid) begin
      range_flags_next = base_out_range;
    end
    if (wr_access && aligned && lane0) begin
      unique case (idx)
        IDX_PATTERN_SELECT: pattern_select_next = {2'h0, wbyte[N-1:0]};
        IDX_PATTERN_CONFIG: pattern_config_next = wbyte;
        IDX_RECAL_SETUP: recal_setup_next = wbyte;
        default: begin
          if (idx >= IDX_THRESH_FIRST && idx <= IDX_THRESH_LAST) begin
            thresh_next[3'(idx - IDX_THRESH_FIRST)] = wbyte[6:0];
            if (idx == IDX_THRESH_FIRST && recal_setup_reg[RS_BROADCAST]) begin
              for (int i = 0; i < N; i++) begin
                thresh_next[i] = wbyte[6:0];
              end
            end
          end
        end
      endcase
    end
  end

  // read data and error decided in the setup phase, shown in the access phase
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup_phase) begin
      rdata_next = '0;
      err_next = 1'b0;
      if (!aligned) begin
        err_next = 1'b1;
      end else begin
        unique case (idx)
          IDX_MAIN_STATUS: rdata_next[7:0] = status_view;
          IDX_PATTERN_SELECT: rdata_next[7:0] = pattern_select_reg;
          IDX_PATTERN_CONFIG: rdata_next[7:0] = pattern_config_reg;
          IDX_RANGE_FLAGS: rdata_next[N-1:0] = range_flags_reg;
          IDX_RECAL_SETUP: rdata_next[7:0] = recal_setup_reg;
          default: begin
            if (idx >= IDX_THRESH_FIRST && idx <= IDX_THRESH_LAST) begin
              rdata_next[6:0] = thresh_reg[3'(idx - IDX_THRESH_FIRST)];
            end else begin
              err_next = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // base count update timer, shared by every input and set only by the interval
  always_comb begin
    ivl_limit = IVL_TABLE[cal_code];
    ivl_count_next = ivl_count_reg;
    update_next = 1'b0;
    if (cycle_done) begin
      if (ivl_count_reg + IVL_W'(1) >= ivl_limit) begin
        ivl_count_next = '0;
        update_next = 1'b1;
      end else begin
        ivl_count_next = ivl_count_reg + IVL_W'(1);
      end
    end
  end

  // one register bank for all state above; reset values come from the package
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_select_reg <= RST_PATTERN_SELECT;
      pattern_config_reg <= RST_PATTERN_CONFIG;
      recal_setup_reg <= RST_RECAL_SETUP;
      range_flags_reg <= RST_RANGE_FLAGS[N-1:0];
      for (int i = 0; i < N; i++) begin
        thresh_reg[i] <= RST_THRESHOLD;
      end
      pattern_active_reg <= 1'b0;
      pattern_status_reg <= 1'b0;
      alert_flag_reg <= 1'b0;
      rdata_reg <= '0;
      err_reg <= 1'b0;
      ivl_count_reg <= '0;
      update_reg <= 1'b0;
    end else begin
      pattern_select_reg <= pattern_select_next;
      pattern_config_reg <= pattern_config_next;
      recal_setup_reg <= recal_setup_next;
      range_flags_reg <= range_flags_next;
      for (int i = 0; i < N; i++) begin
        thresh_reg[i] <= thresh_next[i];
      end
      pattern_active_reg <= pattern_active_next;
      pattern_status_reg <= pattern_status_next;
      alert_flag_reg <= alert_flag_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      ivl_count_reg <= ivl_count_next;
      update_reg <= update_next;
    end
  end

  // negative run limit decode; code 3 turns the trigger off
  always_comb begin
    unique case (recal_setup_reg[RS_NEG_HI:RS_NEG_LO])
      2'h0: neg_limit = NEG_LIMIT_8;
      2'h1: neg_limit = NEG_LIMIT_16;
      2'h2: neg_limit = NEG_LIMIT_32;
      default: neg_limit = NEG_LIMIT_32;
    endcase
  end

  // noise side effects; mismatched keep bits are allowed but not advised
  assign noise_clear_neg = sense.noise & {N{cycle_done && !recal_setup_reg[RS_KEEP_NEG]}};

  // one counter per input, all sharing one limit and one keep setting
  for (genvar g = 0; g < N; g++) begin : g_neg
    tpr_neg_counter #(
      .W(NEG_CNT_W)
    ) u_neg (
      .pclk(pclk),
      .presetn(presetn),
      .step(cycle_done),
      .negative(sense.neg_delta[g]),
      .noise_clear(noise_clear_neg[g]),
      .enable(recal_setup_reg[RS_NEG_HI:RS_NEG_LO] != NEG_CODE_OFF),
      .limit(neg_limit),
      .recal(recal.recal_request[g])
    );
  end

  // intermediate data drop is combinational so it acts in the noisy cycle
  // noise is only valid with cycle_done, so stale flags never drop data
  assign recal.clear_intermediate = sense.noise
      & {N{cycle_done && !recal_setup_reg[RS_KEEP_INTD]}};
  assign recal.base_update = update_reg;
  assign recal.samples_log2 = (cal_code >= CAL_CODE_CAP) ? SAMPLES_MAX_LOG2
      : SAMPLES_MIN_LOG2 + 4'(cal_code);

  // thresholds leave as one flat bus, input 1 in the low bits
  for (genvar g = 0; g < N; g++) begin : g_thr
    assign thresholds[g*7 +: 7] = thresh_reg[g];
  end

  // pins; pready stays high because read data is prepared in the setup cycle
  assign touch_block = pattern_active_reg;
  assign alert_n = !alert_flag_reg;
  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = err_reg && psel && penable;

endmodule : tpr_top

// File: verification/tpr_checker.sv
/*
 * Port-level checker for tpr_top, bound into every instance.
 * Assumes one clock pclk and the active-low asynchronous reset presetn.
 */
module tpr_checker
  import tpr_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int N = NUM_INPUTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cycle_done,
  input wire tpr_sense_s sense,
  input wire logic calib_valid,
  input wire logic [N-1:0] base_out_range,
  input wire logic touch_block,
  input wire logic alert_n,
  input wire logic [N*7-1:0] thresholds,
  input wire tpr_recal_s recal
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // base update interval is at least 16 sensing cycles, so 8 quiet clocks follow a pulse
  sequence quiet_s;
    (!recal.base_update) [*8];
  endsequence

  pready_high_a: assert property (pready) else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("stray slverr");
  rdata_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
  thr_write_a: assert property ($changed(thresholds) |-> $past(psel && penable && pwrite))
    else $error("threshold moved without write");
  block_cause_a: assert property ($changed(touch_block) |-> $past(cycle_done))
    else $error("block moved outside sensing");
  alert_cause_a: assert property ($fell(alert_n) |-> $past(cycle_done))
    else $error("alert without sensing");
  upd_space_a: assert property (recal.base_update |=> quiet_s)
    else $error("base update too close");
  recal_cause_a: assert property (|recal.recal_request |-> $past(cycle_done))
    else $error("recal without sensing");
  clr_noise_a: assert property (|recal.clear_intermediate |->
      cycle_done && ((recal.clear_intermediate & ~sense.noise) == '0))
    else $error("clear without noise");
  samples_span_a: assert property (recal.samples_log2 inside {[4:8]})
    else $error("samples out of span");
endmodule : tpr_checker

bind tpr_top tpr_checker #(.ADDR_W(ADDR_W), .N(N)) u_chk (.*);

// File: verification/tpr_front_model.sv
/*
 * Sensing front end model: issues cycle results and calibration results.
 * Assumes the bench drives run, pat, cal_req and cal_val on pclk.
 */
module tpr_front_model
  import tpr_pkg::*;
(
  input wire logic pclk,
  input wire logic run,
  input wire tpr_sense_s pat,
  input wire logic cal_req,
  input wire logic [NUM_INPUTS-1:0] cal_val,
  output logic cycle_done,
  output tpr_sense_s sense,
  output logic calib_valid,
  output logic [NUM_INPUTS-1:0] base_out_range
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cycle_done = 1'b0;
    sense = '0;
    calib_valid = 1'b0;
    base_out_range = '0;
  end
  // data toggles outside its strobe so a design leaning on stale values shows it
  always @(posedge pclk) begin
    cycle_done <= run;
    sense <= run ? pat : tpr_sense_s'(~sense);
    calib_valid <= cal_req;
    base_out_range <= cal_req ? cal_val : ~base_out_range;
  end
endmodule : tpr_front_model

// File: verification/tb_top.sv
/*
 * Self-checking bench for tpr_top: APB register tests and sensing scenarios.
 * Assumes the front end model and the bound checker.
 */
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import tpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, err, cycle_done, calib_valid, touch_block, alert_n;
  logic run = 0, cal_req = 0;
  logic [5:0] cal_val = '0, base_out_range, req_seen, clr_seen;
  logic [41:0] thresholds;
  tpr_sense_s sense, pat = '0;
  tpr_recal_s recal;
  int bad_count = 0, tests_run = 0, wd = 0, n;
  int ivl[3] = '{16, 32, 1024};
  logic [2:0] ivc[3] = '{3'h0, 3'h1, 3'h5};
  int nexp[4] = '{10, 18, 34, 60};
  logic [7:0] kcfg[2] = '{8'h02, 8'h62};
  logic [35:0] rows[7] = '{36'h82_05_05_00_1, 36'h82_05_04_00_0, 36'h82_05_01_04_1,
      36'h80_07_01_30_1, 36'h80_07_21_00_0, 36'h00_07_3F_00_0, 36'h83_05_05_00_1};

  tpr_top u_dut (.*);
  tpr_front_model u_fe (.*);

  always #25 pclk = ~pclk;
  // hang guard, well above the longest interval test
  always @(posedge pclk) begin
    wd++;
    if (wd == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // one APB transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= w ? 4'hF : 4'h0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk); // outputs launched at the access edge are settled here
  endtask : apb

  task automatic sense_once(input tpr_sense_s s);
    @(posedge pclk);
    pat <= s;
    run <= 1;
    @(posedge pclk);
    run <= 0;
    // clear pulse stands with cycle_done, request pulse one edge later
    @(posedge pclk);
    clr_seen = recal.clear_intermediate;
    @(posedge pclk);
    req_seen = recal.recal_request;
    @(posedge pclk);
  endtask : sense_once

  task automatic cal(input logic [5:0] v);
    @(posedge pclk);
    cal_req <= 1;
    cal_val <= v;
    @(posedge pclk);
    cal_req <= 0;
    repeat (2) @(posedge pclk);
  endtask : cal

  task automatic wait_upd();
    n = 0;
    do begin @(posedge pclk); n++; end while (recal.base_update !== 1'b1 && n < 5000);
  endtask : wait_upd

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, IDX_PATTERN_SELECT, 0); `CHK(rd, 32'h3F)
    `CHK(thresholds, {6{7'h40}})
    `CHK(recal.samples_log2, 4'h6)
    `CHK(alert_n, 1'b1)
    apb(0, IDX_RECAL_SETUP, 0); `CHK(rd, 32'h8A)
    apb(0, IDX_PATTERN_CONFIG, 0); `CHK(rd, 32'h0)
    apb(0, 8'h10, 0); `CHK(err, 1'b1)
    $display("test reset done");
    apb(1, IDX_RANGE_FLAGS, 8'h3F);
    apb(0, IDX_RANGE_FLAGS, 0); `CHK(rd, 32'h0)
    cal(6'h21);
    apb(0, IDX_RANGE_FLAGS, 0); `CHK(rd, 32'h21)
    apb(0, IDX_MAIN_STATUS, 0); `CHK(rd[ST_BASE_FAULT], 1'b1)
    cal(6'h00);
    apb(0, IDX_MAIN_STATUS, 0); `CHK(rd[ST_BASE_FAULT], 1'b0)
    $display("test range done");
    apb(1, IDX_THRESH_FIRST, 8'h15);
    for (int i = 0; i < 6; i++) `CHK(thresholds[i*7+:7], 7'h15)
    apb(1, 8'h32, 8'h22);
    `CHK(thresholds[20:14], 7'h22)
    `CHK(thresholds[13:7], 7'h15)
    apb(1, IDX_RECAL_SETUP, 8'h0A);
    apb(1, IDX_THRESH_FIRST, 8'h11);
    `CHK(thresholds[6:0], 7'h11)
    `CHK(thresholds[41:35], 7'h15)
    $display("test thresholds done");
    for (int c = 0; c < 8; c++) begin
      apb(1, IDX_RECAL_SETUP, {5'h01, 3'(c)});
      `CHK(recal.samples_log2, (c > 4) ? 4'h8 : 4'(c + 4))
    end
    run <= 1;
    foreach (ivl[k]) begin
      apb(1, IDX_RECAL_SETUP, {5'h01, ivc[k]});
      wait_upd();
      wait_upd();
      `CHK(n, ivl[k])
    end
    $display("test recalibration timing done");
    foreach (nexp[k]) begin
      pat <= '0;
      apb(1, IDX_RECAL_SETUP, {3'h0, 2'(k), 3'h2});
      pat <= {6'h00, 6'h00, 6'h3F};
      n = 0;
      do begin @(posedge pclk); n++; end while (recal.recal_request === 6'h00 && n < 60);
      `CHK(n, nexp[k])
      `CHK(recal.recal_request, (k < 3) ? 6'h3F : 6'h00)
    end
    run <= 0;
    $display("test negative count done");
    foreach (kcfg[k]) begin
      apb(1, IDX_RECAL_SETUP, kcfg[k]);
      sense_once('0);
      repeat (5) sense_once({6'h00, 6'h00, 6'h3F});
      sense_once({6'h00, 6'h01, 6'h3F});
      `CHK(clr_seen, (k == 0) ? 6'h01 : 6'h00)
      repeat (2) sense_once({6'h00, 6'h00, 6'h3F});
      `CHK(req_seen, (k == 0) ? 6'h3E : 6'h3F)
    end
    $display("test noise keep done");
    foreach (rows[k]) begin
      sense_once('0);
      `CHK(touch_block, 1'b0)
      apb(1, IDX_MAIN_STATUS, 8'h00);
      apb(1, IDX_PATTERN_CONFIG, rows[k][35:28]);
      apb(1, IDX_PATTERN_SELECT, rows[k][27:20]);
      sense_once({rows[k][17:12], rows[k][9:4], 6'h00});
      `CHK(touch_block, rows[k][0])
      `CHK(alert_n, ~(rows[k][0] & rows[k][28]))
      apb(0, IDX_MAIN_STATUS, 0);
      `CHK(rd[ST_PATTERN], rows[k][0])
      `CHK(rd[ST_ALERT], rows[k][0] & rows[k][28])
      apb(1, IDX_MAIN_STATUS, 8'h00);
      apb(0, IDX_MAIN_STATUS, 0);
      `CHK(rd[ST_PATTERN], rows[k][0])
      `CHK(rd[ST_ALERT], 1'b0)
    end
    $display("test pattern done");
    complete_run();
  end
endmodule : tb_top
